// file: include/rx_ctrl_pkg.sv
// constants for the per-channel receive control register bank
`default_nettype none
package rx_ctrl_pkg;
  localparam int num_channels = 12;
  localparam int chan_w = 4;
  localparam logic [3:0] rc_low_nibble = 4'h5;
  localparam logic [7:0] rc_reset = 8'h00;
  localparam logic [7:0] rc_write_mask = 8'h3f;
  localparam int bit_digital_loss_off = 5;
  localparam int bit_analog_loss_off = 4;
  localparam int bit_clk_edge = 3;
  localparam int bit_mute = 2;
  localparam int bit_monitor = 1;
  localparam int bit_eq_en = 0;
endpackage
`default_nettype wire

// file: core/rx_channel_datapath.sv
// per-channel receive control decode and recovered data launch stage
`timescale 1ns/1ns
`default_nettype none
module rx_channel_datapath (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] ctrl_in,
  input wire logic e3_mode_in,
  input wire logic signal_loss_condition_in,
  input wire logic pos_in,
  input wire logic neg_in,
  output logic digital_detector_en_out,
  output logic analog_detector_en_out,
  output logic monitor_mode_out,
  output logic equalizer_en_out,
  output logic recovered_positive_rail_out,
  output logic recovered_negative_rail_out,
  output logic launch_falling_out
);
  logic mute;
  logic pos_d, neg_d, pos_q, neg_q;

  // detector disables apply only outside e3 mode
  assign digital_detector_en_out = e3_mode_in | ~ctrl_in[rx_ctrl_pkg::bit_digital_loss_off];
  assign analog_detector_en_out = e3_mode_in | ~ctrl_in[rx_ctrl_pkg::bit_analog_loss_off];
  assign monitor_mode_out = ctrl_in[rx_ctrl_pkg::bit_monitor];
  assign equalizer_en_out = ctrl_in[rx_ctrl_pkg::bit_eq_en];
  assign launch_falling_out = ctrl_in[rx_ctrl_pkg::bit_clk_edge];
  assign mute = ctrl_in[rx_ctrl_pkg::bit_mute] & signal_loss_condition_in;

  always_comb begin
    pos_d = pos_in & ~mute;
    neg_d = neg_in & ~mute;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pos_q <= 1'b0;
      neg_q <= 1'b0;
    end else begin
      pos_q <= pos_d;
      neg_q <= neg_d;
    end
  end

  assign recovered_positive_rail_out = pos_q;
  assign recovered_negative_rail_out = neg_q;
endmodule
`default_nettype wire

// file: core/rx_channel_control_reg.sv
// receive control register bank, one register per channel
`timescale 1ns/1ns
`default_nettype none
module rx_channel_control_reg (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] addr_in,
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out,
  input wire logic [11:0] e3_mode_in,
  input wire logic [11:0] signal_loss_condition_in,
  input wire logic [11:0] pos_in,
  input wire logic [11:0] neg_in,
  output logic [11:0] digital_detector_en_out,
  output logic [11:0] analog_detector_en_out,
  output logic [11:0] monitor_mode_out,
  output logic [11:0] equalizer_en_out,
  output logic [11:0] launch_falling_out,
  output logic [11:0] recovered_positive_rail_out,
  output logic [11:0] recovered_negative_rail_out
);
  ////////////////////////////////////////////////////////////////
  // address decode
  function automatic logic hit(input logic [7:0] a, input int ch);
    hit = (a[3:0] == rx_ctrl_pkg::rc_low_nibble) && (a[7:4] == 4'(ch));
  endfunction

  // one field bit picked out of a byte
  function automatic logic field_of(input logic [7:0] v, input int pos);
    field_of = v[pos];
  endfunction

  // reset level of one field, spread over all channels
  function automatic logic [rx_ctrl_pkg::num_channels-1:0] reset_vec(input int pos);
    reset_vec = {rx_ctrl_pkg::num_channels{field_of(rx_ctrl_pkg::rc_reset, pos)}};
  endfunction

  logic [rx_ctrl_pkg::num_channels-1:0] sel_hit;
  logic [rx_ctrl_pkg::num_channels-1:0] wr_hit;
  logic [rx_ctrl_pkg::num_channels-1:0] digital_off_q;
  logic [rx_ctrl_pkg::num_channels-1:0] digital_off_d;
  logic [rx_ctrl_pkg::num_channels-1:0] analog_off_q;
  logic [rx_ctrl_pkg::num_channels-1:0] analog_off_d;
  logic [rx_ctrl_pkg::num_channels-1:0] clk_edge_q;
  logic [rx_ctrl_pkg::num_channels-1:0] clk_edge_d;
  logic [rx_ctrl_pkg::num_channels-1:0] mute_q;
  logic [rx_ctrl_pkg::num_channels-1:0] mute_d;
  logic [rx_ctrl_pkg::num_channels-1:0] monitor_q;
  logic [rx_ctrl_pkg::num_channels-1:0] monitor_d;
  logic [rx_ctrl_pkg::num_channels-1:0] eq_en_q;
  logic [rx_ctrl_pkg::num_channels-1:0] eq_en_d;
  logic [7:0] receive_control [rx_ctrl_pkg::num_channels];
  logic [7:0] read_word;
  logic unmapped;

  ////////////////////////////////////////////////////////////////
  // channel select and write strobes
  generate
    for (genvar k = 0; k < rx_ctrl_pkg::num_channels; k++) begin : gen_dec
      assign sel_hit[k] = hit(addr_in, k);
      assign wr_hit[k] = wr_in & sel_hit[k];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // digital detector disable
  always_comb begin
    digital_off_d = digital_off_q;
    for (int i = 0; i < rx_ctrl_pkg::num_channels; i++) begin
      if (wr_hit[i]) begin
        digital_off_d[i] = field_of(wdata_in, rx_ctrl_pkg::bit_digital_loss_off);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      digital_off_q <= reset_vec(rx_ctrl_pkg::bit_digital_loss_off);
    end else begin
      digital_off_q <= digital_off_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // analog detector disable
  always_comb begin
    analog_off_d = analog_off_q;
    for (int i = 0; i < rx_ctrl_pkg::num_channels; i++) begin
      if (wr_hit[i]) begin
        analog_off_d[i] = field_of(wdata_in, rx_ctrl_pkg::bit_analog_loss_off);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      analog_off_q <= reset_vec(rx_ctrl_pkg::bit_analog_loss_off);
    end else begin
      analog_off_q <= analog_off_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // recovered clock edge select
  always_comb begin
    clk_edge_d = clk_edge_q;
    for (int i = 0; i < rx_ctrl_pkg::num_channels; i++) begin
      if (wr_hit[i]) begin
        clk_edge_d[i] = field_of(wdata_in, rx_ctrl_pkg::bit_clk_edge);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      clk_edge_q <= reset_vec(rx_ctrl_pkg::bit_clk_edge);
    end else begin
      clk_edge_q <= clk_edge_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // mute on signal loss enable
  always_comb begin
    mute_d = mute_q;
    for (int i = 0; i < rx_ctrl_pkg::num_channels; i++) begin
      if (wr_hit[i]) begin
        mute_d[i] = field_of(wdata_in, rx_ctrl_pkg::bit_mute);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mute_q <= reset_vec(rx_ctrl_pkg::bit_mute);
    end else begin
      mute_q <= mute_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // monitor mode enable
  always_comb begin
    monitor_d = monitor_q;
    for (int i = 0; i < rx_ctrl_pkg::num_channels; i++) begin
      if (wr_hit[i]) begin
        monitor_d[i] = field_of(wdata_in, rx_ctrl_pkg::bit_monitor);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      monitor_q <= reset_vec(rx_ctrl_pkg::bit_monitor);
    end else begin
      monitor_q <= monitor_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // equalizer enable
  always_comb begin
    eq_en_d = eq_en_q;
    for (int i = 0; i < rx_ctrl_pkg::num_channels; i++) begin
      if (wr_hit[i]) begin
        eq_en_d[i] = field_of(wdata_in, rx_ctrl_pkg::bit_eq_en);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      eq_en_q <= reset_vec(rx_ctrl_pkg::bit_eq_en);
    end else begin
      eq_en_q <= eq_en_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // register word per channel, reserved bits held at zero
  always_comb begin
    for (int i = 0; i < rx_ctrl_pkg::num_channels; i++) begin
      receive_control[i] = 8'h00;
      receive_control[i][rx_ctrl_pkg::bit_digital_loss_off] = digital_off_q[i];
      receive_control[i][rx_ctrl_pkg::bit_analog_loss_off] = analog_off_q[i];
      receive_control[i][rx_ctrl_pkg::bit_clk_edge] = clk_edge_q[i];
      receive_control[i][rx_ctrl_pkg::bit_mute] = mute_q[i];
      receive_control[i][rx_ctrl_pkg::bit_monitor] = monitor_q[i];
      receive_control[i][rx_ctrl_pkg::bit_eq_en] = eq_en_q[i];
    end
  end

  ////////////////////////////////////////////////////////////////
  // read path, zero for addresses that select no channel
  always_comb begin
    read_word = 8'h00;
    for (int i = 0; i < rx_ctrl_pkg::num_channels; i++) begin
      if (sel_hit[i]) begin
        read_word = receive_control[i];
      end
    end
  end

  assign unmapped = ~|sel_hit;
  assign rdata_out = unmapped ? 8'h00 : (read_word & rx_ctrl_pkg::rc_write_mask);

  ////////////////////////////////////////////////////////////////
  // per-channel receive sections
  genvar g;
  generate
    for (g = 0; g < rx_ctrl_pkg::num_channels; g++) begin : gen_ch
      rx_channel_datapath u_ch (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ctrl_in(receive_control[g]),
        .e3_mode_in(e3_mode_in[g]),
        .signal_loss_condition_in(signal_loss_condition_in[g]),
        .pos_in(pos_in[g]),
        .neg_in(neg_in[g]),
        .digital_detector_en_out(digital_detector_en_out[g]),
        .analog_detector_en_out(analog_detector_en_out[g]),
        .monitor_mode_out(monitor_mode_out[g]),
        .equalizer_en_out(equalizer_en_out[g]),
        .recovered_positive_rail_out(recovered_positive_rail_out[g]),
        .recovered_negative_rail_out(recovered_negative_rail_out[g]),
        .launch_falling_out(launch_falling_out[g])
      );
    end
  endgenerate
endmodule
`default_nettype wire

// file: testbench/rx_ctrl_monitor.sv
// assertions on the receive control register bank ports
`timescale 1ns/1ns
`default_nettype none
module rx_ctrl_monitor (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [7:0] rdata_out,
  input wire logic [11:0] e3_mode_in,
  input wire logic [11:0] signal_loss_condition_in,
  input wire logic [11:0] pos_in,
  input wire logic [11:0] neg_in,
  input wire logic [11:0] digital_detector_en_out,
  input wire logic [11:0] analog_detector_en_out,
  input wire logic [11:0] monitor_mode_out,
  input wire logic [11:0] equalizer_en_out,
  input wire logic [11:0] launch_falling_out,
  input wire logic [11:0] recovered_positive_rail_out,
  input wire logic [11:0] recovered_negative_rail_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire logic sel = addr_in == 8'h35;
  sequence wr3; wr_in && sel ##1 sel; endsequence
  sequence muted; sel && rdata_out[2] && signal_loss_condition_in[3]; endsequence
  a_write_read_back: assert property (wr3 |-> rdata_out == ($past(wdata_in) & 8'h3f))
    else $error("readback differs");
  a_unmapped_zero: assert property (addr_in[3:0] != 4'h5 || addr_in[7:4] > 4'hb |-> !rdata_out)
    else $error("unmapped read not zero");
  a_reserved_zero: assert property (rdata_out[7:6] == 2'b00)
    else $error("reserved bits set");
  a_digital_enable: assert property (sel |-> digital_detector_en_out[3] == (e3_mode_in[3] || !rdata_out[5]))
    else $error("digital detector enable wrong");
  a_analog_enable: assert property (sel |-> analog_detector_en_out[3] == (e3_mode_in[3] || !rdata_out[4]))
    else $error("analog detector enable wrong");
  a_clock_edge: assert property (sel |-> launch_falling_out[3] == rdata_out[3])
    else $error("edge select wrong");
  a_monitor_equalizer: assert property (sel |-> {monitor_mode_out[3], equalizer_en_out[3]} == rdata_out[1:0])
    else $error("monitor or equalizer wrong");
  a_rails_muted: assert property (muted |=> !recovered_positive_rail_out[3] && !recovered_negative_rail_out[3])
    else $error("rails not muted");
  a_rails_follow: assert property (sel && !rdata_out[2] |=> recovered_positive_rail_out[3] == $past(pos_in[3]))
    else $error("rail not passed");
endmodule
bind rx_channel_control_reg rx_ctrl_monitor mon (
  .clk_in(clk_in),
  .rst_in(rst_in),
  .wr_in(wr_in),
  .addr_in(addr_in),
  .wdata_in(wdata_in),
  .rdata_out(rdata_out),
  .e3_mode_in(e3_mode_in),
  .signal_loss_condition_in(signal_loss_condition_in),
  .pos_in(pos_in),
  .neg_in(neg_in),
  .digital_detector_en_out(digital_detector_en_out),
  .analog_detector_en_out(analog_detector_en_out),
  .monitor_mode_out(monitor_mode_out),
  .equalizer_en_out(equalizer_en_out),
  .launch_falling_out(launch_falling_out),
  .recovered_positive_rail_out(recovered_positive_rail_out),
  .recovered_negative_rail_out(recovered_negative_rail_out)
);
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench for the receive control register bank
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0;
  logic [7:0] addr_in = 8'h35, wdata_in = 8'h00, rdata_out;
  logic [11:0] e3_mode_in = 12'h000, signal_loss_condition_in = 12'h000;
  logic [11:0] pos_in = 12'hfff, neg_in = 12'hfff;
  logic [11:0] digital_detector_en_out, analog_detector_en_out, monitor_mode_out;
  logic [11:0] equalizer_en_out, launch_falling_out;
  logic [11:0] recovered_positive_rail_out, recovered_negative_rail_out;
  int mismatches = 0, comparisons = 0;
  logic [15:0] rows [4] = '{16'hff3f, 16'h0000, 16'h2a2a, 16'hd515};
  wire logic [1:0] rails3 = {recovered_positive_rail_out[3], recovered_negative_rail_out[3]};
  rx_channel_control_reg dut (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .addr_in(addr_in),
    .wr_in(wr_in),
    .wdata_in(wdata_in),
    .rdata_out(rdata_out),
    .e3_mode_in(e3_mode_in),
    .signal_loss_condition_in(signal_loss_condition_in),
    .pos_in(pos_in),
    .neg_in(neg_in),
    .digital_detector_en_out(digital_detector_en_out),
    .analog_detector_en_out(analog_detector_en_out),
    .monitor_mode_out(monitor_mode_out),
    .equalizer_en_out(equalizer_en_out),
    .launch_falling_out(launch_falling_out),
    .recovered_positive_rail_out(recovered_positive_rail_out),
    .recovered_negative_rail_out(recovered_negative_rail_out)
  );
  initial forever #50 clk_in = ~clk_in;
  task chk(input string n, input logic [7:0] e, s);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task put(input logic [7:0] a, d, input logic w);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= w;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask
  task give_verdict;
    if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    #1 chk("reset", 8'h00, rdata_out);
    foreach (rows[i]) begin
      put(8'h35, rows[i][15:8], 1'b1);
      chk("readback", rows[i][7:0], rdata_out);
      chk("digital", {7'h0, ~rows[i][5]}, {7'h0, digital_detector_en_out[3]});
      chk("analog", {7'h0, ~rows[i][4]}, {7'h0, analog_detector_en_out[3]});
      chk("edge", {7'h0, rows[i][3]}, {7'h0, launch_falling_out[3]});
      chk("monitor", {7'h0, rows[i][1]}, {7'h0, monitor_mode_out[3]});
      chk("equalizer", {7'h0, rows[i][0]}, {7'h0, equalizer_en_out[3]});
    end
    put(8'hc5, 8'h3f, 1'b1);
    chk("unmapped", 8'h00, rdata_out);
    put(8'h35, 8'h00, 1'b0);
    chk("ignored write", 8'h15, rdata_out);
    put(8'hb5, 8'h02, 1'b1);
    chk("channels", 8'h02, {6'h0, monitor_mode_out[11], monitor_mode_out[3]});
    @(posedge clk_in);
    addr_in <= 8'h35;
    signal_loss_condition_in <= 12'h008;
    e3_mode_in <= 12'h008;
    @(posedge clk_in);
    #1 chk("muted", 8'h00, {6'h0, rails3});
    chk("e3 mode", 8'h15, {3'h0, analog_detector_en_out[3], rdata_out[3:0]});
    @(posedge clk_in);
    signal_loss_condition_in <= 12'h000;
    pos_in <= 12'h000;
    @(posedge clk_in);
    #1 chk("open", 8'h01, {6'h0, rails3});
    put(8'h35, 8'h30, 1'b1);
    chk("e3", 8'h03, {6'h0, digital_detector_en_out[3], analog_detector_en_out[3]});
    @(posedge clk_in);
    e3_mode_in <= 12'h000;
    signal_loss_condition_in <= 12'h008;
    pos_in <= 12'hfff;
    @(posedge clk_in);
    #1 chk("ds3", 8'h00, {6'h0, digital_detector_en_out[3], analog_detector_en_out[3]});
    chk("not muted", 8'h03, {6'h0, rails3});
    for (int c = 0; c < 12; c++) begin
      put({4'(c), 4'h5}, 8'h01, 1'b1);
    end
    chk("equalizers high", 8'hff, equalizer_en_out[11:4]);
    chk("equalizers low", 8'h0f, {4'h0, equalizer_en_out[3:0]});
    give_verdict();
  end
endmodule
`default_nettype wire
